// *** verilog/sdm_regs.svh ***
// Register offsets, field positions, reset values and timing counts of the drive mode block
`ifndef SDM_REGS_SVH
`define SDM_REGS_SVH

// ==========================================================================
// Register byte offsets
`define SDM_OFF_OPMODE      8'h00
`define SDM_OFF_TARGET      8'h04
`define SDM_OFF_CTRLWORD    8'h08
`define SDM_OFF_INTERP      8'h0C
`define SDM_OFF_APPSEL      8'h10
`define SDM_OFF_MODESEL     8'h14
`define SDM_OFF_STORE       8'h18
`define SDM_OFF_SCALE_NUM   8'h1C
`define SDM_OFF_SCALE_DEN   8'h20
`define SDM_OFF_STATUS      8'h24
`define SDM_OFF_SPEED       8'h28
`define SDM_OFF_STEPPOS     8'h2C

// ==========================================================================
// Values
`define SDM_OPMODE_VELOCITY 8'h02
`define SDM_APP_SPECIAL     8'h02
`define SDM_STORE_KEY       32'h65766173
`define SDM_MODE_MAX        8'h0F
`define SDM_OPMODE_RST      8'h00
`define SDM_SCALE_RST       16'h0001
`define SDM_INTERP_RST      16'h0001

// ==========================================================================
// Speeds in rpm and analog thresholds in 10-bit codes
`define SDM_RPM_TEST        16'd30
`define SDM_RPM_HIGH        16'd1000
`define SDM_RPM_LOW         16'd100
`define SDM_ADC_FULL        10'd1023
`define SDM_ADC_MID         10'd512
// 20 mV of 10 V full scale is about two codes
`define SDM_ADC_DEAD        10'd2

// ==========================================================================
// Timing: 1 ms sync base at 25 MHz
`define SDM_CLK_HZ          25000000
`define SDM_SYNC_MS         1
`define SDM_SYNC_CYC        (`SDM_CLK_HZ / 1000 * `SDM_SYNC_MS)

// Status bit positions
`define SDM_ST_SPECIAL      0
`define SDM_ST_ENABLE       1
`define SDM_ST_RUNNING      2
`define SDM_ST_DIR          3
`define SDM_ST_INTERP_BAD   4
`define SDM_ST_MODE_BAD     5

`endif

// *** verilog/sdm_pkg.sv ***
// Types of the drive mode block
package sdm_pkg;
  // ==========================================================================
  // Command source selected by the active mode
  typedef enum logic [1:0] {
    SDM_SRC_BUS,
    SDM_SRC_CLKDIR,
    SDM_SRC_TEST,
    SDM_SRC_ANALOG
  } sdm_src_t;
endpackage

// *** verilog/sdm_sync.sv ***
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module sdm_sync #(
  parameter int W = 1
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  // ==========================================================================
  // First stage feeds only the second
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule // sdm_sync

// *** verilog/sdm_speed.sv ***
// Analog-to-speed mapping: normal and joystick scaling with dead zones
`timescale 1ns/1ps
`include "sdm_regs.svh"
module sdm_speed (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [9:0]  adc,
  input  wire logic        joystick,
  input  wire logic        low_max,
  input  wire logic        dir_in,
  output logic      [15:0] speed_mag,
  output logic             speed_neg
);
  logic [15:0] max_rpm;
  logic [9:0]  span;
  logic [9:0]  full;
  logic        neg;
  logic        dead;
  logic [9:0]  adc_prev_q;
  logic [9:0]  adc_ok_q;

  // Proportional scaling of a code to rpm
  function automatic logic [15:0] scale(input logic [9:0] v, input logic [9:0] f, input logic [15:0] m);
    logic [25:0] p;
    p = 26'(v) * 26'(m);
    return 16'(p / 26'(f));
  endfunction

  // ==========================================================================
  // Pick span, sign and dead zone per scaling mode
  always_comb begin
    max_rpm = low_max ? `SDM_RPM_LOW : `SDM_RPM_HIGH;
    if (joystick) begin
      full = `SDM_ADC_FULL - `SDM_ADC_MID;
      neg  = adc_ok_q < `SDM_ADC_MID;
      span = neg ? (`SDM_ADC_MID - adc_ok_q) : (adc_ok_q - `SDM_ADC_MID);
      dead = span <= `SDM_ADC_DEAD;
      if (neg) full = `SDM_ADC_MID;
    end else begin
      full = `SDM_ADC_FULL;
      neg  = dir_in;
      span = adc_ok_q;
      dead = adc_ok_q <= `SDM_ADC_DEAD;
    end
  end

  // Code bits cross one by one; a code is taken only once two samples agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      adc_prev_q <= 10'h000;
      adc_ok_q   <= 10'h000;
    end else begin
      adc_prev_q <= adc;
      if (adc == adc_prev_q) adc_ok_q <= adc;
    end
  end

  // Registered so the result is stable for a whole cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      speed_mag <= 16'h0000;
      speed_neg <= 1'b0;
    end else begin
      speed_mag <= dead ? 16'h0000 : scale(span, full, max_rpm);
      speed_neg <= neg;
    end
  end
endmodule // sdm_speed

// *** verilog/sdm_top.sv ***
// Drive command selection with AXI4-Lite register access
// Overview of operation
// - Interpolation period is an integer multiple of 1 ms.
// - Operation mode 2 selects velocity operation.
// - Outside special modes, writing zero to the control word stops the motor.
// - In special modes, digital input 1 enables motion.
// - Special modes active only with application value 2 stored.
// - Mode selector holds 00h to 0Fh.
// - Modes 00/01/08/09 select clock-direction operation.
// - Test-run modes rotate at 30 rpm while enabled.
// - 02h/0Ah clockwise; 03h/0Bh counterclockwise.
// - 04/05/0C/0D analog, direction input; 1000 or 100 rpm maximum.
// - 06/07/0E/0F joystick scaling about mid scale; 1000 or 100 rpm.
// - Application and mode selections apply only after save key and restart.
// - Analog modes run velocity and write derived target speed.
// - Maximum speed is 100 or 1000 rpm, else scaling factor.
// - Speed scaling adjustable through numerator and denominator.
// - Normal analog: full scale maps to maximum speed proportionally.
// - Normal analog: direction from input; 0-20 mV dead zone.
// - Joystick: mid scale is zero, below negative, above positive.
// - Joystick: within 20 mV of mid scale gives zero speed.
// - Analog input is a 10-bit converted value.
`timescale 1ns/1ps
`include "sdm_regs.svh"
module sdm_top (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [7:0]       s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  output logic      [1:0]       s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  input  wire logic [7:0]       s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic      [31:0]      s_axi_rdata,
  output logic      [1:0]       s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  input  wire logic             enable_pin,
  input  wire logic             dir_pin,
  input  wire logic             clk_pin,
  input  wire logic [9:0]       adc_code,
  input  wire logic             restart,
  output logic                  motor_run,
  output logic                  motor_dir_ccw,
  output logic      [15:0]      motor_speed,
  output logic                  motor_closed_loop,
  output logic                  step_pulse,
  output logic                  sync_tick,
  output sdm_pkg::sdm_src_t     cmd_source
);
  import sdm_pkg::*;
  // ==========================================================================
  // Register state
  logic [7:0]  opmode_q;
  logic [15:0] target_q;
  logic [15:0] ctrl_q;
  logic [15:0] interp_q;
  logic [7:0]  app_pend_q;
  logic [7:0]  mode_pend_q;
  logic [7:0]  app_save_q;
  logic [7:0]  mode_save_q;
  logic [7:0]  app_act_q;
  logic [7:0]  mode_act_q;
  logic [15:0] num_q;
  logic [15:0] den_q;
  logic [31:0] steppos_q;
  logic        mode_bad_q;
  logic [24:0] sync_cnt_q;
  logic [15:0] interp_cnt_q;
  // Synchronised pins
  logic        en_s;
  logic        dir_s;
  logic        clk_s;
  logic        clk_prev_q;
  logic [9:0]  adc_s;
  sdm_sync #(.W(3)) u_pins (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       ({enable_pin, dir_pin, clk_pin}),
    .q       ({en_s, dir_s, clk_s})
  );
  // Converter code is sampled through the same two stages
  sdm_sync #(.W(10)) u_adc (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       (adc_code),
    .q       (adc_s)
  );
  // ==========================================================================
  // AXI4-Lite write channel: address and data taken in either order
  logic        aw_hold_q;
  logic        w_hold_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        do_write;
  assign do_write = aw_hold_q && w_hold_q && !s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q     <= 1'b0;
      w_hold_q      <= 1'b0;
      awaddr_q      <= 8'h00;
      wdata_q       <= 32'h00000000;
      wstrb_q       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
    end else begin
      s_axi_awready <= !aw_hold_q && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_hold_q && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= known(awaddr_q) ? 2'b00 : 2'b10;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  // Decode of mapped offsets, shared by read and write
  function automatic logic known(input logic [7:0] a);
    return a <= `SDM_OFF_STEPPOS && a[1:0] == 2'b00;
  endfunction
  // Byte-lane merge of a write into a register
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction
  function automatic logic wr(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction
  // ==========================================================================
  // Bus object registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      opmode_q    <= `SDM_OPMODE_RST;
      target_q    <= 16'h0000;
      ctrl_q      <= 16'h0000;
      interp_q    <= `SDM_INTERP_RST;
      app_pend_q  <= 8'h00;
      mode_pend_q <= 8'h00;
      num_q       <= `SDM_SCALE_RST;
      den_q       <= `SDM_SCALE_RST;
      mode_bad_q  <= 1'b0;
    end else if (do_write) begin
      if (wr(awaddr_q, `SDM_OFF_OPMODE))   opmode_q <= 8'(merge(32'(opmode_q), wdata_q, wstrb_q));
      if (wr(awaddr_q, `SDM_OFF_TARGET))   target_q <= 16'(merge(32'(target_q), wdata_q, wstrb_q));
      if (wr(awaddr_q, `SDM_OFF_CTRLWORD)) ctrl_q   <= 16'(merge(32'(ctrl_q), wdata_q, wstrb_q));
      // Zero period would stall the interpolation tick, so it is refused
      if (wr(awaddr_q, `SDM_OFF_INTERP) && wdata_q[15:0] != 16'h0000) begin
        interp_q <= 16'(merge(32'(interp_q), wdata_q, wstrb_q));
      end
      if (wr(awaddr_q, `SDM_OFF_APPSEL))   app_pend_q <= 8'(merge(32'(app_pend_q), wdata_q, wstrb_q));
      // Out-of-range selections are dropped and flagged
      if (wr(awaddr_q, `SDM_OFF_MODESEL)) begin
        if (wdata_q[7:0] <= `SDM_MODE_MAX) mode_pend_q <= wdata_q[7:0];
        mode_bad_q <= wdata_q[7:0] > `SDM_MODE_MAX;
      end
      if (wr(awaddr_q, `SDM_OFF_SCALE_NUM)) num_q <= 16'(merge(32'(num_q), wdata_q, wstrb_q));
      if (wr(awaddr_q, `SDM_OFF_SCALE_DEN) && wdata_q[15:0] != 16'h0000) den_q <= wdata_q[15:0];
    end
  end

  // ==========================================================================
  // Saved copy and active copy; active only loads on restart
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      app_save_q  <= 8'h00;
      mode_save_q <= 8'h00;
      app_act_q   <= 8'h00;
      mode_act_q  <= 8'h00;
    end else begin
      if (do_write && wr(awaddr_q, `SDM_OFF_STORE) && wdata_q == `SDM_STORE_KEY) begin
        app_save_q  <= app_pend_q;
        mode_save_q <= mode_pend_q;
      end
      if (restart) begin
        app_act_q  <= app_save_q;
        mode_act_q <= mode_save_q;
      end
    end
  end
  // ==========================================================================
  // Mode decode
  logic     special;
  logic     enabled;
  sdm_src_t src;
  assign special   = app_act_q == `SDM_APP_SPECIAL;
  assign enabled   = en_s;

  always_comb begin
    if (!special) begin
      src = SDM_SRC_BUS;
    end else if (mode_act_q[2:1] == 2'b00) begin
      src = SDM_SRC_CLKDIR;
    end else if (mode_act_q[2:1] == 2'b01) begin
      src = SDM_SRC_TEST;
    end else begin
      src = SDM_SRC_ANALOG;
    end
  end
  // Analog mapping; bit 1 picks joystick, bit 0 picks the 100 rpm maximum
  logic [15:0] an_mag;
  logic        an_neg;
  sdm_speed u_speed (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .adc       (adc_s),
    .joystick  (mode_act_q[1]),
    .low_max   (mode_act_q[0]),
    .dir_in    (dir_s),
    .speed_mag (an_mag),
    .speed_neg (an_neg)
  );
  // Applies the user scaling factor
  function automatic logic [15:0] user_scale(input logic [15:0] v, input logic [15:0] n, input logic [15:0] d);
    logic [31:0] p;
    p = 32'(v) * 32'(n);
    return 16'(p / 32'(d));
  endfunction

  // ==========================================================================
  // Sync base tick every 1 ms; interpolation tick every interp_q ticks
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_cnt_q   <= 25'd0;
      interp_cnt_q <= 16'h0000;
      sync_tick    <= 1'b0;
    end else begin
      sync_tick <= 1'b0;
      if (sync_cnt_q == 25'(`SDM_SYNC_CYC - 1)) begin
        sync_cnt_q <= 25'd0;
        if (interp_cnt_q >= interp_q - 16'h0001) begin
          interp_cnt_q <= 16'h0000;
          sync_tick    <= 1'b1;
        end else begin
          interp_cnt_q <= interp_cnt_q + 16'h0001;
        end
      end else begin
        sync_cnt_q <= sync_cnt_q + 25'd1;
      end
    end
  end

  // ==========================================================================
  // Clock-direction stepping on rising clock edges
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_prev_q <= 1'b0;
      steppos_q  <= 32'h00000000;
      step_pulse <= 1'b0;
    end else begin
      clk_prev_q <= clk_s;
      step_pulse <= 1'b0;
      if (src == SDM_SRC_CLKDIR && enabled && clk_s && !clk_prev_q) begin
        step_pulse <= 1'b1;
        steppos_q  <= dir_s ? steppos_q - 32'h00000001 : steppos_q + 32'h00000001;
      end
    end
  end

  // ==========================================================================
  // Motor command outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      motor_run         <= 1'b0;
      motor_dir_ccw     <= 1'b0;
      motor_speed       <= 16'h0000;
      motor_closed_loop <= 1'b0;
      cmd_source        <= SDM_SRC_BUS;
    end else begin
      cmd_source        <= src;
      motor_closed_loop <= special && mode_act_q[3];
      unique case (src)
        SDM_SRC_BUS: begin
          // Velocity only with mode 2 and a non-zero control word
          motor_run     <= opmode_q == `SDM_OPMODE_VELOCITY && ctrl_q != 16'h0000;
          motor_dir_ccw <= target_q[15];
          motor_speed   <= target_q[15] ? 16'(-target_q) : target_q;
        end
        SDM_SRC_CLKDIR: begin
          motor_run     <= enabled;
          motor_dir_ccw <= dir_s;
          motor_speed   <= 16'h0000;
        end
        SDM_SRC_TEST: begin
          motor_run     <= enabled;
          motor_dir_ccw <= mode_act_q[0];
          motor_speed   <= user_scale(`SDM_RPM_TEST, num_q, den_q);
        end
        SDM_SRC_ANALOG: begin
          motor_run     <= enabled && an_mag != 16'h0000;
          motor_dir_ccw <= an_neg;
          motor_speed   <= user_scale(an_mag, num_q, den_q);
        end
      endcase
    end
  end

  // ==========================================================================
  // Read channel, one cycle answer after address taken
  logic [31:0] rd_mux;
  logic [15:0] tgt_view;
  // Analog modes show the derived target speed in the target register
  assign tgt_view = (src == SDM_SRC_ANALOG) ? (an_neg ? 16'(-an_mag) : an_mag) : target_q;

  always_comb begin
    rd_mux = 32'h00000000;
    unique case (s_axi_araddr)
      `SDM_OFF_OPMODE:    rd_mux = {24'h000000, (src == SDM_SRC_ANALOG) ? `SDM_OPMODE_VELOCITY : opmode_q};
      `SDM_OFF_TARGET:    rd_mux = {16'h0000, tgt_view};
      `SDM_OFF_CTRLWORD:  rd_mux = {16'h0000, ctrl_q};
      `SDM_OFF_INTERP:    rd_mux = {16'h0000, interp_q};
      `SDM_OFF_APPSEL:    rd_mux = {24'h000000, app_pend_q};
      `SDM_OFF_MODESEL:   rd_mux = {24'h000000, mode_pend_q};
      `SDM_OFF_SCALE_NUM: rd_mux = {16'h0000, num_q};
      `SDM_OFF_SCALE_DEN: rd_mux = {16'h0000, den_q};
      `SDM_OFF_STATUS:    rd_mux = {26'h0000000, mode_bad_q, 1'b0, motor_dir_ccw, motor_run, en_s, special};
      `SDM_OFF_SPEED:     rd_mux = {16'h0000, motor_speed};
      `SDM_OFF_STEPPOS:   rd_mux = steppos_q;
      default:            rd_mux = 32'h00000000;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= 2'b00;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_mux;
        s_axi_rresp  <= known(s_axi_araddr) ? 2'b00 : 2'b10;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // sdm_top

// *** sim/sdm_monitor.sv ***
// Checker of drive command outputs and sync timing of sdm_top
`timescale 1ns/1ps
`include "sdm_regs.svh"
module sdm_monitor (
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic              enable_pin,
  input wire logic              motor_run,
  input wire logic [15:0]       motor_speed,
  input wire logic              motor_closed_loop,
  input wire logic              step_pulse,
  input wire logic              sync_tick,
  input wire sdm_pkg::sdm_src_t cmd_source
);
  import sdm_pkg::*;
  logic [15:0] gap_q;
  logic        seen_q;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================================================
  // Cycles since the last sync tick
  always_ff @(posedge aclk) begin
    if (!aresetn || sync_tick)
      gap_q <= 16'h0000;
    else
      gap_q <= gap_q + 16'h0001;
  end
  // First tick has no reference to measure from
  always_ff @(posedge aclk) begin
    if (!aresetn)
      seen_q <= 1'b0;
    else if (sync_tick)
      seen_q <= 1'b1;
  end
  // Settled states; four cycles cover the registered output lag, six for idle_s through the pin synchroniser
  sequence idle_s;
    (!enable_pin && cmd_source != SDM_SRC_BUS) [*6];
  endsequence
  sequence clkdir_s;
    (cmd_source == SDM_SRC_CLKDIR) [*4];
  endsequence
  sequence test_s;
    (cmd_source == SDM_SRC_TEST) [*4];
  endsequence
  step_once_a: assert property (step_pulse |=> !step_pulse)
    else $error("step pulse wider than one cycle");
  step_src_a: assert property (step_pulse |-> cmd_source == SDM_SRC_CLKDIR)
    else $error("step pulse outside clock-direction");
  clkdir_speed_a: assert property (clkdir_s |-> motor_speed == 16'h0000)
    else $error("speed set in clock-direction");
  test_speed_a: assert property (test_s ##0 motor_run |-> motor_speed == `SDM_RPM_TEST)
    else $error("test run speed wrong");
  enable_gate_a: assert property (idle_s |-> !motor_run)
    else $error("motor driven without enable");
  enable_start_a: assert property ($rose(enable_pin) && cmd_source == SDM_SRC_TEST |-> ##[3:8] motor_run)
    else $error("test run did not start");
  closed_src_a: assert property (motor_closed_loop |-> cmd_source != SDM_SRC_BUS)
    else $error("closed loop outside special mode");
  sync_gap_a: assert property (sync_tick && seen_q |-> gap_q == `SDM_SYNC_CYC - 1)
    else $error("sync period wrong");
endmodule // sdm_monitor

bind sdm_top sdm_monitor sdm_monitor_inst (.aclk(aclk), .aresetn(aresetn), .enable_pin(enable_pin),
  .motor_run(motor_run), .motor_speed(motor_speed), .motor_closed_loop(motor_closed_loop),
  .step_pulse(step_pulse), .sync_tick(sync_tick), .cmd_source(cmd_source));

// *** sim/sdm_pins.sv ***
// Model of the pin-side command sources: enable, direction, step clock, converter
`timescale 1ns/1ps
module sdm_pins (
  input  wire logic       aclk,
  output logic            enable_pin,
  output logic            dir_pin,
  output logic            clk_pin,
  output logic      [9:0] adc_code
);
  // ==========================================================================
  // Idle pins; the step clock stands low between pulses
  initial begin
    enable_pin = 1'b0;
    dir_pin = 1'b0;
    clk_pin = 1'b0;
    adc_code = 10'h000;
  end
  // Levels change together just after an edge
  task pins_set(input logic en, input logic d, input logic [9:0] a);
    @(posedge aclk);
    enable_pin <= en;
    dir_pin <= d;
    adc_code <= a;
  endtask
  // Slow pulses, so the two-flop synchroniser sees every edge
  task steps(input int n);
    repeat (n) begin
      repeat (4) @(posedge aclk);
      clk_pin <= 1'b1;
      repeat (4) @(posedge aclk);
      clk_pin <= 1'b0;
    end
  endtask
endmodule // sdm_pins

// *** sim/testbench.sv ***
// Self-checking bench of sdm_top: registers, mode selection, pin behaviour
`timescale 1ns/1ps
`include "sdm_regs.svh"
module testbench;
  import sdm_pkg::*;
  logic        aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, restart = 1'b0;
  logic        bready = 1'b1, rready = 1'b1;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic        aclk, awready, wready, bvalid, arready, rvalid, run, ccw, closed, en, dir, cpin;
  logic [1:0]  bresp, rresp, resp;
  logic [9:0]  adc;
  logic [15:0] speed;
  logic [31:0] rdata, rdat;
  sdm_src_t    src;
  int          bad_count, checks, cyc;
  // ==========================================================================
  sdm_top sdm_top_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .enable_pin(en), .dir_pin(dir), .clk_pin(cpin), .adc_code(adc), .restart(restart), .motor_run(run),
    .motor_dir_ccw(ccw), .motor_speed(speed), .motor_closed_loop(closed), .step_pulse(), .sync_tick(),
    .cmd_source(src));
  sdm_pins sdm_pins_inst (.aclk(aclk), .enable_pin(en), .dir_pin(dir), .clk_pin(cpin), .adc_code(adc));
  // 25 MHz clock
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  // Hang guard
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      bad_count++;
      end_of_test();
    end
  end
  task cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task cmpb(input string n, input logic e, input logic g);
    cmp(n, {31'h0, e}, {31'h0, g});
  endtask
  task end_of_test;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Ready channels held high throughout, so no release is needed
  task wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    do @(posedge aclk); while (bvalid !== 1'b1);
    resp = bresp;
  endtask
  task rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rdat = rdata;
    resp = rresp;
  endtask
  task reboot;
    restart <= 1'b1;
    @(posedge aclk);
    restart <= 1'b0;
    repeat (8) @(posedge aclk);
  endtask
  task setmode(input logic [7:0] m);
    wr(`SDM_OFF_APPSEL, 32'h2);
    wr(`SDM_OFF_MODESEL, {24'h0, m});
    wr(`SDM_OFF_STORE, `SDM_STORE_KEY);
    reboot();
  endtask
  // Main sequence
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`SDM_OFF_OPMODE);
    cmp("opmode", 32'h0, rdat);
    rd(8'h30);
    cmp("unmapped", 32'h2, {30'h0, resp});
    wr(`SDM_OFF_INTERP, 32'h0);
    rd(`SDM_OFF_INTERP);
    cmp("interp", 32'h1, rdat);
    wr(`SDM_OFF_OPMODE, 32'h2);
    wr(`SDM_OFF_TARGET, 32'h0000_FF38);
    wr(`SDM_OFF_CTRLWORD, 32'h1);
    repeat (4) @(posedge aclk);
    cmpb("bus run", 1'b1, run);
    cmp("bus speed", 32'd200, {16'h0, speed});
    cmpb("bus ccw", 1'b1, ccw);
    wr(`SDM_OFF_CTRLWORD, 32'h0);
    repeat (4) @(posedge aclk);
    cmpb("stop", 1'b0, run);
    for (int m = 0; m < 16; m++) begin
      logic [3:0] v;
      v = m[3:0];
      sdm_pins_inst.pins_set(1'b1, 1'b0, v[2:1] == 2'd3 ? 10'd513 : `SDM_ADC_FULL);
      setmode({4'h0, v});
      cmp("source", v[2:1] == 2'd0 ? 32'd1 : v[2:1] == 2'd1 ? 32'd2 : 32'd3, {30'h0, src});
      cmpb("loop", v[3], closed);
      cmp("speed", v[2:1] == 2'd1 ? 32'd30 : v[2:1] != 2'd2 ? 32'd0 : v[0] ? 32'd100 : 32'd1000, {16'h0, speed});
      if (v[2:1] == 2'd1)
        cmpb("test dir", v[0], ccw);
    end
    wr(`SDM_OFF_MODESEL, 32'h3);
    wr(`SDM_OFF_STORE, `SDM_STORE_KEY);
    repeat (8) @(posedge aclk);
    cmp("no restart", 32'd3, {30'h0, src});
    reboot();
    cmp("restart", 32'd2, {30'h0, src});
    sdm_pins_inst.pins_set(1'b0, 1'b0, 10'd0);
    repeat (8) @(posedge aclk);
    cmpb("disabled", 1'b0, run);
    sdm_pins_inst.pins_set(1'b1, 1'b0, `SDM_ADC_DEAD);
    repeat (8) @(posedge aclk);
    cmpb("enabled", 1'b1, run);
    setmode(8'h04);
    cmp("dead zone", 32'h0, {16'h0, speed});
    sdm_pins_inst.pins_set(1'b1, 1'b1, `SDM_ADC_FULL);
    repeat (10) @(posedge aclk);
    cmpb("analog ccw", 1'b1, ccw);
    rd(`SDM_OFF_TARGET);
    cmp("derived target", 32'h0000_FC18, rdat);
    wr(`SDM_OFF_SCALE_DEN, 32'h2);
    repeat (4) @(posedge aclk);
    cmp("scaled speed", 32'd500, {16'h0, speed});
    wr(`SDM_OFF_SCALE_DEN, 32'h1);
    sdm_pins_inst.pins_set(1'b1, 1'b0, 10'd0);
    setmode(8'h06);
    cmp("joystick speed", 32'd1000, {16'h0, speed});
    cmpb("joystick ccw", 1'b1, ccw);
    setmode(8'h00);
    sdm_pins_inst.steps(3);
    sdm_pins_inst.pins_set(1'b1, 1'b1, 10'd0);
    sdm_pins_inst.steps(1);
    repeat (6) @(posedge aclk);
    rd(`SDM_OFF_STEPPOS);
    cmp("steps", 32'd2, rdat);
    wr(`SDM_OFF_MODESEL, 32'h10);
    rd(`SDM_OFF_STATUS);
    cmpb("mode bad", 1'b1, rdat[`SDM_ST_MODE_BAD]);
    repeat (52000) @(posedge aclk);
    end_of_test();
  end
endmodule // testbench
